// file: logic/cram_dev.sv
// remap control registers and code fetch steering
`timescale 1ns/1ps
`default_nettype none
// Operation
// R1 - code and data are separate 64K spaces
// R2 - after reset ram only in data space
// R3 - committed select maps ram into code fetches
// R4 - vector select one fetches vectors from ram
// R5 - vector select zero uses top of code
// R6 - software sets both selects before key
// R7 - serial mode always maps ram into code
// R8 - unmapped ram window fetches software interrupt
// R9 - only 2K boot rom outside serial mode
// R10 - select change waits for commit key
// R11 - key D4 commits; other values ignored
// R12 - commit register is write only
// R13 - reset-disable commit uses key B2
// R14 - flag-clear commit uses key 71
// R15 - status shows committed selects bits 1,2
// R16 - bits 7..3 read zero
// R17 - vector select zero in loader uses boot; the code decodes these vector fetches as flash instead
// R18 - commit on key edge; reset clears all
module cram_dev
	import cram_pkg::*;
(
	// clock and reset
	input wire logic core_clk_in,
	input wire logic rst_n_in,
	// mode and mapping inputs
	input wire logic serial_mode_in,
	input wire logic boot_map_in,
	// cpu side
	cram_if.dev bus,
	// mapping state and commit pulses for the rest of the chip
	output logic ram_to_code_active_out,
	output logic vector_table_active_out,
	output logic rstdis_commit_out,
	output logic flagclr_commit_out
);
	logic [2:0] ctrl_ff;
	logic [2:0] nxt_ctrl;
	logic ram_code_ff;
	logic nxt_ram_code;
	logic vec_ff;
	logic nxt_vec;
	logic rstdis_ff;
	logic nxt_rstdis;
	logic rstdis_pulse_ff;
	logic nxt_rstdis_pulse;
	logic flagclr_pulse_ff;
	logic nxt_flagclr_pulse;
	logic [7:0] rdata_ff;
	logic [7:0] nxt_rdata;
	logic rvalid_ff;
	logic nxt_rvalid;
	logic [15:0] phys_ff;
	logic [15:0] nxt_phys;
	logic swi_ff;
	logic nxt_swi;
	logic [7:0] opc_ff;
	logic [7:0] nxt_opc;
	cram_src_e fsrc_ff;
	cram_src_e nxt_fsrc;
	cram_src_e fsrc_dec;
	cram_src_e dsrc_dec;
	logic wr_ctrl;
	logic wr_key;
	logic rd;
	logic [15:0] fa;
	logic vcall_rom;
	logic vint_rom;

	cram_decode u_dec (
		.ram_code_in(ram_code_ff),
		.serial_mode_in(serial_mode_in),
		.boot_map_in(boot_map_in),
		.fetch_addr_in(bus.fetch_addr),
		.data_addr_in(bus.data_addr),
		.fetch_src_out(fsrc_dec),
		.data_src_out(dsrc_dec)
	);

	assign wr_ctrl = bus.data_valid && bus.data_write && (bus.data_addr == CRAM_OFS_MAP_CTRL);
	assign wr_key = bus.data_valid && bus.data_write && (bus.data_addr == CRAM_OFS_COMMIT_KEY);
	assign rd = bus.data_valid && !bus.data_write;

	// register group
	always_comb begin
		nxt_ctrl = ctrl_ff;
		nxt_ram_code = ram_code_ff;
		nxt_vec = vec_ff;
		nxt_rstdis = rstdis_ff;
		nxt_rstdis_pulse = 1'b0;
		nxt_flagclr_pulse = 1'b0;
		if (wr_ctrl) begin
			nxt_ctrl = bus.data_wdata[2:0]; // pending only, see R10
		end
		if (wr_key) begin
			case (bus.data_wdata)
				CRAM_KEY_MAP: begin
					// pending value written in the same cycle is not yet held, so use ctrl_ff
					nxt_ram_code = ctrl_ff[CRAM_BIT_RAM_CODE]; // see R11, see R18
					nxt_vec = ctrl_ff[CRAM_BIT_VECTOR]; // see R11
					nxt_rstdis = ctrl_ff[0];
				end
				// other party keeps the mode and gear conditions for these keys
				CRAM_KEY_RSTDIS: begin
					nxt_rstdis = ctrl_ff[0];
					nxt_rstdis_pulse = 1'b1; // see R13
				end
				CRAM_KEY_FLAGCLR: begin
					nxt_flagclr_pulse = 1'b1; // see R14
				end
				default: begin
				end
			endcase
		end
		nxt_rdata = 8'h00;
		nxt_rvalid = rd;
		if (rd && (bus.data_addr == CRAM_OFS_MAP_CTRL)) begin
			nxt_rdata = {5'h00, ctrl_ff}; // see R16
		end else if (rd && (bus.data_addr == CRAM_OFS_MAP_STAT)) begin
			nxt_rdata = {5'h00, vec_ff, ram_code_ff, rstdis_ff}; // see R15, see R16
		end
		// commit key register reads zero, see R12
	end

	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			ctrl_ff <= CRAM_RST_CTRL[2:0]; // see R18
			ram_code_ff <= 1'b0; // see R2
			vec_ff <= 1'b0;
			rstdis_ff <= 1'b0;
			rstdis_pulse_ff <= 1'b0;
			flagclr_pulse_ff <= 1'b0;
			rdata_ff <= 8'h00;
			rvalid_ff <= 1'b0;
		end else begin
			ctrl_ff <= nxt_ctrl;
			ram_code_ff <= nxt_ram_code;
			vec_ff <= nxt_vec;
			rstdis_ff <= nxt_rstdis;
			rstdis_pulse_ff <= nxt_rstdis_pulse;
			flagclr_pulse_ff <= nxt_flagclr_pulse;
			rdata_ff <= nxt_rdata;
			rvalid_ff <= nxt_rvalid;
		end
	end

	// fetch steering group
	assign fa = bus.fetch_addr;
	assign vcall_rom = (fa >= CRAM_VCALL_ROM_LO) && (fa < CRAM_VINT_ROM_LO);
	assign vint_rom = (fa >= CRAM_VINT_ROM_LO);

	always_comb begin
		nxt_fsrc = fsrc_dec;
		nxt_phys = fa;
		nxt_swi = 1'b0;
		nxt_opc = 8'h00;
		if (bus.fetch_valid) begin
			// vectors relocate to ram only while vec select committed, see R4, see R5
			if (vec_ff && vcall_rom && (fa - CRAM_VCALL_ROM_LO <= CRAM_VCALL_RAM_HI - CRAM_VCALL_RAM_LO)) begin
				nxt_fsrc = CRAM_SRC_RAM;
				nxt_phys = CRAM_VCALL_RAM_LO + (fa - CRAM_VCALL_ROM_LO); // see R4
			end else if (vec_ff && vint_rom && (fa - CRAM_VINT_ROM_LO <= CRAM_VINT_RAM_HI - CRAM_VINT_RAM_LO)) begin
				nxt_fsrc = CRAM_SRC_RAM;
				nxt_phys = CRAM_VINT_RAM_LO + (fa - CRAM_VINT_ROM_LO); // see R4
			end else if (fsrc_dec == CRAM_SRC_SWI) begin
				nxt_swi = 1'b1; // see R8
				nxt_opc = CRAM_SWI_OPCODE;
			end
			// with vec at zero, loader vectors fall to top of code and decode as flash, not the boot area, see R17
		end else begin
			nxt_fsrc = CRAM_SRC_NONE;
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			fsrc_ff <= CRAM_SRC_NONE;
			phys_ff <= 16'h0000;
			swi_ff <= 1'b0;
			opc_ff <= 8'h00;
		end else begin
			fsrc_ff <= nxt_fsrc;
			phys_ff <= nxt_phys;
			swi_ff <= nxt_swi;
			opc_ff <= nxt_opc;
		end
	end

	assign bus.data_rdata = rdata_ff;
	assign bus.data_rdata_valid = rvalid_ff;
	assign bus.fetch_src = fsrc_ff;
	assign bus.fetch_phys = phys_ff;
	assign bus.fetch_swi = swi_ff;
	assign bus.fetch_opcode = opc_ff;
	assign bus.data_src = dsrc_dec;
	assign bus.vector_in_ram = vec_ff;
	assign ram_to_code_active_out = ram_code_ff;
	assign vector_table_active_out = vec_ff;
	assign rstdis_commit_out = rstdis_pulse_ff;
	assign flagclr_commit_out = flagclr_pulse_ff;
endmodule : cram_dev
`default_nettype wire

// file: inc/cram_pkg.sv
// package for the code-area ram remap control block
package cram_pkg;
	localparam logic [15:0] CRAM_OFS_MAP_CTRL = 16'h0FDE;
	localparam logic [15:0] CRAM_OFS_MAP_STAT = 16'h0FDF;
	// no printed address for the commit key register
	localparam logic [15:0] CRAM_OFS_COMMIT_KEY = 16'h0FE0;
	localparam int CRAM_BIT_RAM_CODE = 1;
	localparam int CRAM_BIT_VECTOR = 2;
	localparam logic [7:0] CRAM_RST_CTRL = 8'h00;
	localparam logic [7:0] CRAM_KEY_MAP = 8'hD4;
	localparam logic [7:0] CRAM_KEY_RSTDIS = 8'hB2;
	localparam logic [7:0] CRAM_KEY_FLAGCLR = 8'h71;
	localparam logic [7:0] CRAM_SWI_OPCODE = 8'hFF;
	localparam logic [15:0] CRAM_RAM_LO = 16'h0040;
	localparam logic [15:0] CRAM_RAM_HI = 16'h083F;
	localparam logic [15:0] CRAM_VCALL_RAM_LO = 16'h01A0;
	localparam logic [15:0] CRAM_VCALL_RAM_HI = 16'h01BF;
	localparam logic [15:0] CRAM_VINT_RAM_LO = 16'h01CC;
	localparam logic [15:0] CRAM_VINT_RAM_HI = 16'h01FD;
	localparam logic [15:0] CRAM_VCALL_ROM_LO = 16'hFFA0;
	localparam logic [15:0] CRAM_VINT_ROM_LO = 16'hFFCC;
	localparam logic [15:0] CRAM_BOOT_LO = 16'h1000;
	localparam logic [15:0] CRAM_BOOT_HI = 16'h17FF;
	localparam logic [15:0] CRAM_FLASH_LO = 16'h8000;
	localparam logic [15:0] CRAM_SFR2_LO = 16'h0F00;
	localparam logic [15:0] CRAM_SFR2_HI = 16'h0FFF;
	typedef enum logic [2:0] {
		CRAM_SRC_NONE,
		CRAM_SRC_RAM,
		CRAM_SRC_SWI,
		CRAM_SRC_BOOT,
		CRAM_SRC_FLASH,
		CRAM_SRC_SFR
	} cram_src_e;
	typedef enum logic [1:0] {
		CRAM_ACC_IDLE,
		CRAM_ACC_WRITE,
		CRAM_ACC_READ
	} cram_acc_e;
endpackage : cram_pkg

// file: inc/cram_if.sv
// interface joining cpu access side and remap control
`timescale 1ns/1ps
`default_nettype none
interface cram_if;
	import cram_pkg::*;
	logic fetch_valid;
	logic [15:0] fetch_addr;
	logic data_valid;
	logic data_write;
	logic [15:0] data_addr;
	logic [7:0] data_wdata;
	logic [7:0] data_rdata;
	logic data_rdata_valid;
	cram_src_e fetch_src;
	logic [15:0] fetch_phys;
	logic fetch_swi;
	logic [7:0] fetch_opcode;
	cram_src_e data_src;
	logic vector_in_ram;
	modport dev (input fetch_valid, fetch_addr, data_valid, data_write, data_addr, data_wdata,
		output data_rdata, data_rdata_valid, fetch_src, fetch_phys, fetch_swi, fetch_opcode,
		data_src, vector_in_ram);
	modport cpu (output fetch_valid, fetch_addr, data_valid, data_write, data_addr, data_wdata,
		input data_rdata, data_rdata_valid, fetch_src, fetch_phys, fetch_swi, fetch_opcode,
		data_src, vector_in_ram);
endinterface : cram_if
`default_nettype wire

// file: logic/cram_decode.sv
// address decoder for code and data spaces
`timescale 1ns/1ps
`default_nettype none
module cram_decode
	import cram_pkg::*;
(
	// mapping state
	input wire logic ram_code_in,
	input wire logic serial_mode_in,
	input wire logic boot_map_in,
	// addresses
	input wire logic [15:0] fetch_addr_in,
	input wire logic [15:0] data_addr_in,
	// results
	output cram_src_e fetch_src_out,
	output cram_src_e data_src_out
);
	logic ram_win;
	logic boot_win;
	logic boot_win_d;
	assign ram_win = (fetch_addr_in >= CRAM_RAM_LO) && (fetch_addr_in <= CRAM_RAM_HI);
	assign boot_win = (fetch_addr_in >= CRAM_BOOT_LO) && (fetch_addr_in <= CRAM_BOOT_HI);
	assign boot_win_d = (data_addr_in >= CRAM_BOOT_LO) && (data_addr_in <= CRAM_BOOT_HI);
	// code space decode (separate from data space) see R1
	always_comb begin
		fetch_src_out = CRAM_SRC_NONE;
		if (ram_win) begin
			// serial mode forces ram in regardless of select see R7
			if (ram_code_in || serial_mode_in) begin // see R3
				fetch_src_out = CRAM_SRC_RAM;
			end else begin
				fetch_src_out = CRAM_SRC_SWI; // see R2, see R8
			end
		end else if (boot_win && (boot_map_in || serial_mode_in)) begin
			fetch_src_out = CRAM_SRC_BOOT; // see R9
		end else if (fetch_addr_in >= CRAM_FLASH_LO) begin
			fetch_src_out = CRAM_SRC_FLASH;
		end
	end
	always_comb begin
		data_src_out = CRAM_SRC_NONE;
		if ((data_addr_in >= CRAM_RAM_LO) && (data_addr_in <= CRAM_RAM_HI)) begin
			data_src_out = CRAM_SRC_RAM; // see R2
		end else if ((data_addr_in >= CRAM_SFR2_LO) && (data_addr_in <= CRAM_SFR2_HI)) begin
			data_src_out = CRAM_SRC_SFR;
		end else if (boot_win_d && (boot_map_in || serial_mode_in)) begin
			data_src_out = CRAM_SRC_BOOT; // see R9
		end else if (data_addr_in >= CRAM_FLASH_LO) begin
			data_src_out = CRAM_SRC_FLASH;
		end
	end
endmodule : cram_decode
`default_nettype wire

// file: logic/cram_cpu.sv
// cpu-side end: turns simple user requests into fetch and data cycles
`timescale 1ns/1ps
`default_nettype none
module cram_cpu
	import cram_pkg::*;
(
	// clock and reset
	input wire logic core_clk_in,
	input wire logic rst_n_in,
	// user requests
	input wire logic fetch_req_in,
	input wire logic [15:0] fetch_addr_in,
	input wire logic data_req_in,
	input wire logic data_write_in,
	input wire logic [15:0] data_addr_in,
	input wire logic [7:0] data_wdata_in,
	// user answers
	output logic [7:0] data_rdata_out,
	output logic data_rdata_valid_out,
	output logic fetch_swi_out,
	output logic [15:0] fetch_phys_out,
	// remap control side
	cram_if.cpu bus
);
	logic fv_ff;
	logic [15:0] fa_ff;
	logic dv_ff;
	logic dw_ff;
	logic [15:0] da_ff;
	logic [7:0] dd_ff;
	logic is_key;
	assign is_key = data_addr_in == CRAM_OFS_COMMIT_KEY;
	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			fv_ff <= 1'b0;
			fa_ff <= 16'h0000;
			dv_ff <= 1'b0;
			dw_ff <= 1'b0;
			da_ff <= 16'h0000;
			dd_ff <= 8'h00;
		end else begin
			fv_ff <= fetch_req_in;
			fa_ff <= fetch_addr_in;
			// the key register is never read, so reads of it are dropped see R12
			dv_ff <= data_req_in && (data_write_in || !is_key);
			dw_ff <= data_write_in;
			da_ff <= data_addr_in;
			dd_ff <= data_wdata_in;
		end
	end
	assign bus.fetch_valid = fv_ff;
	assign bus.fetch_addr = fa_ff;
	assign bus.data_valid = dv_ff;
	assign bus.data_write = dw_ff;
	assign bus.data_addr = da_ff;
	assign bus.data_wdata = dd_ff;
	assign data_rdata_out = bus.data_rdata;
	assign data_rdata_valid_out = bus.data_rdata_valid;
	assign fetch_swi_out = bus.fetch_swi;
	assign fetch_phys_out = bus.fetch_phys;
endmodule : cram_cpu
`default_nettype wire

// file: verification/cram_monitor.sv
// assertion checker on the remap control interface
`timescale 1ns/1ps
`default_nettype none
module cram_monitor
	import cram_pkg::*;
(
	// clock and reset
	input wire logic core_clk_in,
	input wire logic rst_n_in,
	// interface signals
	input wire logic fetch_valid,
	input wire logic [15:0] fetch_addr,
	input wire logic data_valid,
	input wire logic data_write,
	input wire logic [15:0] data_addr,
	input wire logic [7:0] data_wdata,
	input wire logic [7:0] data_rdata,
	input wire logic data_rdata_valid,
	input wire cram_src_e fetch_src,
	input wire logic [15:0] fetch_phys,
	input wire logic fetch_swi,
	input wire logic [7:0] fetch_opcode,
	input wire cram_src_e data_src,
	input wire logic vector_in_ram
);
	logic f_ram;
	logic f_vec;
	logic key_d4;
	logic rd_stat;
	logic rd_ctrl;
	default clocking @(posedge core_clk_in);
	endclocking
	default disable iff (!rst_n_in);
	assign f_ram = fetch_valid && fetch_addr >= CRAM_RAM_LO && fetch_addr <= CRAM_RAM_HI;
	// the reset vector pair at the very top never moves to ram
	assign f_vec = fetch_valid && ((fetch_addr >= CRAM_VCALL_ROM_LO && fetch_addr <= 16'hFFBF)
		|| (fetch_addr >= CRAM_VINT_ROM_LO && fetch_addr <= 16'hFFFD));
	assign key_d4 = data_valid && data_write && data_addr == CRAM_OFS_COMMIT_KEY
		&& data_wdata == CRAM_KEY_MAP;
	assign rd_stat = data_valid && !data_write && data_addr == CRAM_OFS_MAP_STAT;
	assign rd_ctrl = data_valid && !data_write && data_addr == CRAM_OFS_MAP_CTRL;
	swi_opcode_a: assert property (fetch_swi |-> fetch_opcode == CRAM_SWI_OPCODE)
		else $error("swi fetch without swi opcode");
	ram_window_a: assert property (f_ram |=> (fetch_src inside {CRAM_SRC_RAM, CRAM_SRC_SWI})
		&& fetch_swi == (fetch_src == CRAM_SRC_SWI)) else $error("ram window source wrong");
	idle_swi_a: assert property (!fetch_valid |=> !fetch_swi)
		else $error("swi with no fetch");
	vec_ram_a: assert property (f_vec && vector_in_ram |=> fetch_src == CRAM_SRC_RAM
		&& fetch_phys == (16'h0100 | ($past(fetch_addr) & 16'h00FF))) else $error("ram vector");
	vec_rom_a: assert property (f_vec && !vector_in_ram |=> fetch_phys == $past(fetch_addr))
		else $error("top vector moved");
	status_read_a: assert property (rd_stat |=> data_rdata_valid && data_rdata[7:3] == 5'h00
		&& data_rdata[2] == vector_in_ram) else $error("status read wrong");
	ctrl_read_a: assert property (rd_ctrl |=> data_rdata_valid && data_rdata[7:3] == 5'h00)
		else $error("control high bits set");
	vec_commit_a: assert property (!$stable(vector_in_ram) |-> $past(key_d4))
		else $error("vector select moved without key");
	// ram stays in the data space even while the code window fetches the trap opcode
	data_ram_a: assert property (data_valid && data_addr >= CRAM_RAM_LO
		&& data_addr <= CRAM_RAM_HI |-> data_src == CRAM_SRC_RAM) else $error("data ram lost");
	cover property (fetch_swi);
	cover property ($rose(vector_in_ram));
	cover property (f_vec && vector_in_ram);
endmodule : cram_monitor
`default_nettype wire

// file: verification/code_area_ram_remap_control_tb.sv
// self-checking bench joining the cpu end and the remap control end
`timescale 1ns/1ps
`default_nettype none
module code_area_ram_remap_control_tb
	import cram_pkg::*;
;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic serial = 1'b0;
	logic boot = 1'b0;
	logic f_req = 1'b0;
	logic [15:0] f_addr = 16'h0000;
	logic d_req = 1'b0;
	logic d_wr = 1'b0;
	logic [15:0] d_addr = 16'h0000;
	logic [7:0] d_wdata = 8'h00;
	logic [7:0] rdata;
	logic rvalid, software_interrupt_opcode, ram_act, vec_act, rstdis_p, flagclr_p;
	logic [15:0] phys;
	logic [7:0] keys [3] = '{8'h55, CRAM_KEY_RSTDIS, CRAM_KEY_FLAGCLR};
	logic [15:0] vecs [4] = '{16'hFFA0, 16'hFFBF, 16'hFFCC, 16'hFFFD};
	int miscompares = 0;
	int total_checks = 0;
	int cycles = 0;
	cram_if bus_if ();
	cram_dev i_cram_dev (.core_clk_in(clk), .rst_n_in(rst_n), .serial_mode_in(serial),
		.boot_map_in(boot), .bus(bus_if), .ram_to_code_active_out(ram_act),
		.vector_table_active_out(vec_act), .rstdis_commit_out(rstdis_p),
		.flagclr_commit_out(flagclr_p));
	cram_cpu i_cram_cpu (.core_clk_in(clk), .rst_n_in(rst_n), .fetch_req_in(f_req),
		.fetch_addr_in(f_addr), .data_req_in(d_req), .data_write_in(d_wr), .data_addr_in(d_addr),
		.data_wdata_in(d_wdata), .data_rdata_out(rdata), .data_rdata_valid_out(rvalid),
		.fetch_swi_out(software_interrupt_opcode), .fetch_phys_out(phys), .bus(bus_if));
	cram_monitor i_cram_monitor (.core_clk_in(clk), .rst_n_in(rst_n),
		.fetch_valid(bus_if.fetch_valid), .fetch_addr(bus_if.fetch_addr),
		.data_valid(bus_if.data_valid), .data_write(bus_if.data_write),
		.data_addr(bus_if.data_addr), .data_wdata(bus_if.data_wdata),
		.data_rdata(bus_if.data_rdata), .data_rdata_valid(bus_if.data_rdata_valid),
		.fetch_src(bus_if.fetch_src), .fetch_phys(bus_if.fetch_phys),
		.fetch_swi(bus_if.fetch_swi), .fetch_opcode(bus_if.fetch_opcode),
		.data_src(bus_if.data_src), .vector_in_ram(bus_if.vector_in_ram));
	always #50 clk = ~clk;
	task give_verdict();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : give_verdict
	task check(input logic [23:0] seen, input logic [23:0] exp);
		total_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	// answers land two rising edges after the request, so sampling waits for the second falling edge, half a cycle later
	task data_op(input logic wr, input logic [15:0] addr, input logic [7:0] wdata);
		d_req = 1'b1;
		d_wr = wr;
		d_addr = addr;
		d_wdata = wdata;
		@(negedge clk);
		d_req = 1'b0;
		@(negedge clk);
	endtask : data_op
	task rd(input logic [15:0] addr, input logic [7:0] exp);
		data_op(1'b0, addr, 8'h00);
		check({rvalid, rdata}, {1'b1, exp});
	endtask : rd
	task stat_chk(input logic [7:0] exp);
		rd(CRAM_OFS_MAP_STAT, exp);
		check({ram_act, vec_act}, {exp[1], exp[2]});
	endtask : stat_chk
	task fetch_chk(input logic [15:0] addr, input logic exp_swi, input logic [15:0] exp_phys);
		f_req = 1'b1;
		f_addr = addr;
		@(negedge clk);
		f_req = 1'b0;
		@(negedge clk);
		check({software_interrupt_opcode, exp_swi ? 16'h0000 : phys}, {exp_swi, exp_phys});
	endtask : fetch_chk
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			miscompares++;
			give_verdict();
		end
	end
	initial begin
		repeat (6) @(negedge clk);
		rst_n = 1'b1;
		stat_chk(8'h00);
		fetch_chk(CRAM_RAM_LO, 1'b1, 16'h0000);
		fetch_chk(CRAM_RAM_HI, 1'b1, 16'h0000);
		rd(CRAM_RAM_LO, 8'h00);
		data_op(1'b0, CRAM_OFS_COMMIT_KEY, 8'h00);
		check(rvalid, 1'b0);
		boot = 1'b1;
		fetch_chk(CRAM_BOOT_HI, 1'b0, CRAM_BOOT_HI);
		check(bus_if.fetch_src, CRAM_SRC_BOOT);
		fetch_chk(16'h1800, 1'b0, 16'h1800);
		check(bus_if.fetch_src, CRAM_SRC_NONE);
		boot = 1'b0;
		data_op(1'b1, CRAM_OFS_MAP_CTRL, 8'hFE);
		rd(CRAM_OFS_MAP_CTRL, 8'h06);
		for (int i = 0; i < 3; i++) begin
			data_op(1'b1, CRAM_OFS_COMMIT_KEY, keys[i]);
			check({rstdis_p, flagclr_p}, {keys[i] == CRAM_KEY_RSTDIS, keys[i] == CRAM_KEY_FLAGCLR});
			stat_chk(8'h00);
		end
		fetch_chk(CRAM_RAM_LO, 1'b1, 16'h0000);
		data_op(1'b1, CRAM_OFS_COMMIT_KEY, CRAM_KEY_MAP);
		stat_chk(8'h06);
		fetch_chk(CRAM_RAM_LO, 1'b0, CRAM_RAM_LO);
		fetch_chk(CRAM_RAM_HI, 1'b0, CRAM_RAM_HI);
		for (int i = 0; i < 4; i++) begin
			fetch_chk(vecs[i], 1'b0, {8'h01, vecs[i][7:0]});
		end
		data_op(1'b1, CRAM_OFS_MAP_CTRL, 8'h02);
		data_op(1'b1, CRAM_OFS_COMMIT_KEY, CRAM_KEY_MAP);
		stat_chk(8'h02);
		for (int i = 0; i < 4; i++) begin
			fetch_chk(vecs[i], 1'b0, vecs[i]);
		end
		data_op(1'b1, CRAM_OFS_MAP_CTRL, 8'h00);
		data_op(1'b1, CRAM_OFS_COMMIT_KEY, CRAM_KEY_MAP);
		serial = 1'b1;
		fetch_chk(CRAM_RAM_LO, 1'b0, CRAM_RAM_LO);
		fetch_chk(CRAM_VINT_ROM_LO, 1'b0, CRAM_VINT_ROM_LO);
		serial = 1'b0;
		fetch_chk(CRAM_RAM_LO, 1'b1, 16'h0000);
		data_op(1'b1, CRAM_OFS_MAP_CTRL, 8'h06);
		data_op(1'b1, CRAM_OFS_COMMIT_KEY, CRAM_KEY_MAP);
		rst_n = 1'b0;
		repeat (6) @(negedge clk);
		rst_n = 1'b1;
		stat_chk(8'h00);
		rd(CRAM_OFS_MAP_CTRL, 8'h00);
		fetch_chk(CRAM_RAM_LO, 1'b1, 16'h0000);
		give_verdict();
	end
endmodule : code_area_ram_remap_control_tb
`default_nettype wire
